// ==== rtl/mcd_cache_regs.svh ====
// Address map, field positions and timing counts of the mapped cache port.
// Included by the decoder, the port and the bench; holds definitions only.
`ifndef MCD_CACHE_REGS_SVH
`define MCD_CACHE_REGS_SVH

// Region selector in the top byte of the address.
`define MCD_SEL_HI        31
`define MCD_SEL_LO        24
`define MCD_SEL_DATA      8'hF1
`define MCD_SEL_TAG       8'hF0

// Address fields of the array regions: way and entry in both, longword for data, associative bit for tag.
`define MCD_WAY_HI        13
`define MCD_WAY_LO        12
`define MCD_ENT_HI        11
`define MCD_ENT_LO        4
`define MCD_LW_HI         3
`define MCD_LW_LO         2
`define MCD_ASSOC_BIT     3

// Tag array data word layout.
`define MCD_TAG_HI        28
`define MCD_TAG_LO        10
`define MCD_LRU_HI        9
`define MCD_LRU_LO        4
`define MCD_DIRTY_BIT     1
`define MCD_VALID_BIT     0

// Access size code for a longword transfer.
`define MCD_SIZE_LONG     2'h2

// Write-back line length in longwords, and last beat index.
`define MCD_LINE_WORDS    4
`define MCD_LAST_BEAT     2'h3

// Constant fills.
`define MCD_ZERO32        32'h0000_0000
`define MCD_PA_PAD        3'h0
`define MCD_LW_PAD        4'h0

`endif

// ==== rtl/mcd_pkg.sv ====
// Types shared by the mapped cache port design files.
// Assumes the address map header is on the include path.
package mcd_pkg;
   typedef logic [1:0]  mcd_way_t;
   typedef logic [7:0]  mcd_entry_t;
   typedef logic [1:0]  mcd_lw_t;
   typedef logic [18:0] mcd_tag_t;
   typedef logic [5:0]  mcd_lru_t;

   typedef enum logic [1:0] {
      MCD_WB_IDLE = 2'h0,
      MCD_WB_SEND = 2'h1,
      MCD_WB_LAST = 2'h3
   } mcd_wb_state_t;
endpackage

// ==== rtl/mcd_decode.sv ====
// Address decoder of the mapped cache port: region and field extraction.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
`include "mcd_cache_regs.svh"

module mcd_decode
   import mcd_pkg::*;
(
   input  wire logic [31:0] addr,
   output mcd_pkg::mcd_way_t   way,
   output mcd_pkg::mcd_entry_t entry,
   output mcd_pkg::mcd_lw_t    lw,
   output logic             assoc,
   output logic             in_data,
   output logic             in_tag
);

   // -------------------------------------------------------------
   // Region and field decode
   // -------------------------------------------------------------
   // The whole top byte is compared so that the tag region never aliases.
   assign in_data = (addr[`MCD_SEL_HI:`MCD_SEL_LO] == `MCD_SEL_DATA);
   assign in_tag  = (addr[`MCD_SEL_HI:`MCD_SEL_LO] == `MCD_SEL_TAG);
   assign way     = addr[`MCD_WAY_HI:`MCD_WAY_LO];
   assign entry   = addr[`MCD_ENT_HI:`MCD_ENT_LO];
   assign lw      = addr[`MCD_LW_HI:`MCD_LW_LO];
   assign assoc   = addr[`MCD_ASSOC_BIT];

endmodule

// ==== rtl/mcd_port.sv ====
// Mapped cache port: direct software access to the cache data and tag arrays.
// Assumes a CPU master issuing one-cycle read or write strobes, and a memory
// side that accepts write-back longwords with a valid/ready handshake.
//
// Contract
// - Accesses with top byte F1 hit the data array, not ordinary memory.
// - Address bits 31 to 24 equal to F1 select the data array, F0 the tag array.
// - Longword code 00 to 11 picks longword 0 to 3 of a 16-byte line.
// - Way code 00 to 11 picks way 0 to 3.
// - Only full longword transfers are carried out; others are refused.
// - Data array accesses leave tag, order, dirty and valid bits unchanged.
// - A data read returns the chosen longword of the chosen entry and way.
// - A data write stores the word at the chosen longword of entry and way.
// - An associative tag write updates valid and dirty of a matching way only.
// - Clearing valid on a dirty line writes the line back to memory.
// - Entries are indexed by bits 11 to 4, 256 entries in each of four ways.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "mcd_cache_regs.svh"

module mcd_port
   import mcd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_wdata,
   input  wire logic        req_wr,
   input  wire logic        req_rd,
   input  wire logic [1:0]  req_size,
   output logic      [31:0] rd_data,
   output logic             size_err,
   output logic             wb_refused,
   output logic             wb_busy,
   output logic             wb_valid,
   input  wire logic        wb_ready,
   output logic      [31:0] wb_addr,
   output logic      [31:0] wb_data
);

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   mcd_way_t   way;
   mcd_entry_t entry;
   mcd_lw_t    lw;
   logic       assoc;
   logic       in_data;
   logic       in_tag;

   mcd_decode u_decode (
      .addr    (req_addr),
      .way     (way),
      .entry   (entry),
      .lw      (lw),
      .assoc   (assoc),
      .in_data (in_data),
      .in_tag  (in_tag)
   );

   logic        is_long;
   logic        any_req;
   logic        d_wr;
   logic        d_rd;
   logic        t_wr;
   logic        t_rd;
   logic [11:0] d_idx;
   logic [9:0]  t_idx;

   assign is_long = (req_size == `MCD_SIZE_LONG);
   assign any_req = req_wr | req_rd;
   assign d_wr    = req_wr & is_long & in_data;
   assign d_rd    = req_rd & is_long & in_data;
   assign t_wr    = req_wr & is_long & in_tag;
   assign t_rd    = req_rd & is_long & in_tag;
   // Longword position forms the lowest index bits, so 00 is longword 0.
   assign d_idx   = {way, entry, lw};
   assign t_idx   = {way, entry};

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   logic [31:0] data_mem [0:4095];
   mcd_tag_t    tag_mem  [0:1023];
   mcd_lru_t    lru_mem  [0:255];
   logic [1023:0] valid_bits;
   logic [1023:0] dirty_bits;

   // -------------------------------------------------------------
   // Associative compare
   // -------------------------------------------------------------
   mcd_tag_t   wr_tag;
   logic [3:0] way_hit;
   logic       any_hit;
   mcd_way_t   hit_way;

   assign wr_tag = req_wdata[`MCD_TAG_HI:`MCD_TAG_LO];

   genvar gw;
   generate
      for (gw = 0; gw < 4; gw++) begin : g_cmp
         assign way_hit[gw] = valid_bits[{2'(gw), entry}]
                              && (tag_mem[{2'(gw), entry}] == wr_tag);
      end
   endgenerate

   assign any_hit = |way_hit;

   always_comb begin
      hit_way = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (way_hit[i]) begin
            hit_way = i[1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Tag write target and write-back decision
   // -------------------------------------------------------------
   logic [9:0] tgt_idx;
   logic       tgt_hit;
   logic       new_v;
   logic       new_u;
   logic       need_wb;
   logic       tag_go;
   logic       wb_start;

   assign tgt_idx = assoc ? {hit_way, entry} : t_idx;
   assign tgt_hit = assoc ? any_hit : 1'b1;
   assign new_v   = req_wdata[`MCD_VALID_BIT];
   assign new_u   = req_wdata[`MCD_DIRTY_BIT];

   // A dirty valid line that is overwritten or invalidated must leave first.
   always_comb begin
      if (assoc) begin
         need_wb = tgt_hit && !new_v && dirty_bits[tgt_idx];
      end else begin
         need_wb = valid_bits[tgt_idx] && dirty_bits[tgt_idx];
      end
   end

   // The buffer holds one line, so a second eviction while it drains is refused
   // whole rather than lose the dirty line.
   assign tag_go   = t_wr && tgt_hit && !(need_wb && wb_busy);
   assign wb_start = tag_go && need_wb;

   // -------------------------------------------------------------
   // Data array
   // -------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (d_wr) begin
         data_mem[d_idx] <= req_wdata;
      end
   end

   // -------------------------------------------------------------
   // Tag array
   // -------------------------------------------------------------
   // Only tag region writes reach these stores; the data region has no path.
   always_ff @(posedge clock) begin
      if (tag_go && !assoc) begin
         tag_mem[t_idx]  <= wr_tag;
         lru_mem[entry]  <= req_wdata[`MCD_LRU_HI:`MCD_LRU_LO];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         valid_bits <= '0;
         dirty_bits <= '0;
      end else if (tag_go) begin
         valid_bits[tgt_idx] <= new_v;
         dirty_bits[tgt_idx] <= new_u;
      end
   end

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   logic [31:0] next_rd_data;

   always_comb begin
      next_rd_data = `MCD_ZERO32;
      if (d_rd) begin
         next_rd_data = data_mem[d_idx];
      end else if (t_rd) begin
         // The associative flag is ignored on reads.
         next_rd_data = {`MCD_PA_PAD, tag_mem[t_idx], lru_mem[entry],
                         2'h0, dirty_bits[t_idx], valid_bits[t_idx]};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data <= `MCD_ZERO32;
      end else if (req_rd) begin
         rd_data <= next_rd_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         size_err <= 1'b0;
      end else begin
         size_err <= any_req && (in_data || in_tag) && !is_long;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wb_refused <= 1'b0;
      end else begin
         wb_refused <= t_wr && tgt_hit && need_wb && wb_busy;
      end
   end

   // -------------------------------------------------------------
   // Write-back engine
   // -------------------------------------------------------------
   mcd_wb_state_t wb_state;
   mcd_wb_state_t next_wb_state;
   logic [1:0]    wb_beat;
   logic          wb_take;
   logic [31:0]   wb_buf [0:4];

   assign wb_take  = wb_valid && wb_ready;
   assign wb_busy  = (wb_state != MCD_WB_IDLE);
   assign wb_valid = wb_busy;
   assign wb_data  = wb_buf[0];
   assign wb_buf[4] = `MCD_ZERO32;

   always_comb begin
      next_wb_state = wb_state;
      case (wb_state)
         MCD_WB_IDLE: begin
            if (wb_start) begin
               next_wb_state = MCD_WB_SEND;
            end
         end
         MCD_WB_SEND: begin
            if (wb_take && wb_beat == `MCD_LAST_BEAT - 2'h1) begin
               next_wb_state = MCD_WB_LAST;
            end
         end
         MCD_WB_LAST: begin
            if (wb_take) begin
               next_wb_state = MCD_WB_IDLE;
            end
         end
         default: begin
            next_wb_state = MCD_WB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wb_state <= MCD_WB_IDLE;
      end else begin
         wb_state <= next_wb_state;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wb_beat <= 2'h0;
      end else if (wb_start) begin
         wb_beat <= 2'h0;
      end else if (wb_take) begin
         wb_beat <= wb_beat + 2'h1;
      end
   end

   // Physical line address is rebuilt from the stored tag and the entry.
   always_ff @(posedge clock) begin
      if (rst) begin
         wb_addr <= `MCD_ZERO32;
      end else if (wb_start) begin
         wb_addr <= {`MCD_PA_PAD, tag_mem[tgt_idx], entry[5:0], `MCD_LW_PAD};
      end else if (wb_take) begin
         wb_addr[`MCD_LW_HI:`MCD_LW_LO] <= wb_beat + 2'h1;
      end
   end

   // The line is copied out at once so later data writes cannot corrupt it.
   genvar gb;
   generate
      for (gb = 0; gb < `MCD_LINE_WORDS; gb++) begin : g_buf
         always_ff @(posedge clock) begin
            if (rst) begin
               wb_buf[gb] <= `MCD_ZERO32;
            end else if (wb_start) begin
               wb_buf[gb] <= data_mem[{tgt_idx, 2'(gb)}];
            end else if (wb_take) begin
               wb_buf[gb] <= wb_buf[gb + 1];
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_wb_go;
      wb_start;
   endsequence

   sequence s_wb_drain;
      wb_take && wb_state == MCD_WB_LAST;
   endsequence

   chk_data_store: assert property (
      d_wr |=> data_mem[$past(d_idx)] == $past(req_wdata))
      else $error("data array write did not store the word");

   chk_data_fetch: assert property (
      d_rd |=> rd_data == data_mem[$past(d_idx)])
      else $error("data array read returned the wrong longword");

   chk_tag_untouched: assert property (
      (d_wr || d_rd) |=> $stable(valid_bits) && $stable(dirty_bits))
      else $error("data array access changed tag state");

   chk_size_refused: assert property (
      (req_wr && in_data && !is_long) |=> size_err && $stable(valid_bits))
      else $error("non-longword access was not refused");

   chk_unmapped_zero: assert property (
      (req_rd && !in_data && !in_tag) |=> rd_data == `MCD_ZERO32)
      else $error("unmapped read did not return zero");

   chk_assoc_miss: assert property (
      (t_wr && assoc && !any_hit) |=> $stable(valid_bits) && $stable(dirty_bits))
      else $error("associative miss changed tag state");

   chk_assoc_hit: assert property (
      (t_wr && assoc && any_hit && !wb_busy) |=>
         valid_bits[$past(tgt_idx)] == $past(new_v))
      else $error("associative hit did not update valid flag");

   chk_wb_launch: assert property (
      s_wb_go |=> wb_valid && wb_beat == 2'h0 && wb_data == $past(data_mem[{tgt_idx, 2'h0}]))
      else $error("write-back did not start with longword 0");

   chk_wb_refuse: assert property (
      (t_wr && tgt_hit && need_wb && wb_busy) |=> wb_refused && $stable(valid_bits))
      else $error("eviction during busy write-back was not refused");

   chk_wb_beats: assert property (
      s_wb_drain |-> wb_beat == `MCD_LAST_BEAT)
      else $error("write-back ended on the wrong beat");

endmodule

// ==== verif/mcd_mem_model.sv ====
// Memory-side sink for the write-back link of the mapped cache port.
// Assumes one clock shared with the port and a synchronous active-high reset.
`timescale 1ns/1ps

module mcd_mem_model
   import mcd_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        wb_valid,
   input  wire logic [31:0] wb_addr,
   input  wire logic [31:0] wb_data,
   output logic             wb_ready
);
   // ------------------------------------
   // Ready generation and beat capture
   // ------------------------------------
   // A slow memory stalls at random, so every beat has to hold until it is taken.
   int          seed = 80182;
   logic [31:0] cap_addr [$];
   logic [31:0] cap_data [$];

   initial wb_ready = 1'b0;

   always @(posedge clock) begin
      wb_ready <= !rst && (!slow || ($random(seed) % 2 != 0));
      if (!rst && wb_valid && wb_ready) begin
         cap_addr.push_back(wb_addr);
         cap_data.push_back(wb_data);
      end
   end
endmodule

// ==== verif/tb_mapped_cache_data_array_port.sv ====
// Self-checking bench for the mapped cache port, with random and corner accesses.
// Assumes the package, the address map header and the memory model come first.
`timescale 1ns/1ps
`include "mcd_cache_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb_mapped_cache_data_array_port
   import mcd_pkg::*;
();
   // ------------------------------------
   // Signals and helpers
   // ------------------------------------
   logic        clock;
   logic        rst;
   logic        req_wr;
   logic        req_rd;
   logic        slow;
   logic        wb_ready;
   logic        wb_valid;
   logic        wb_busy;
   logic        size_err;
   logic        wb_refused;
   logic [1:0]  req_size;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic [31:0] rd_data;
   logic [31:0] wb_addr;
   logic [31:0] wb_data;
   logic [31:0] shadow [logic [11:0]];
   int          fail_count;
   int          check_count;
   int          seed = 80182;
   localparam logic [7:0]  en = 8'h5A;
   localparam logic [18:0] tg = 19'h2_1234;
   localparam logic [18:0] tg2 = 19'h0_5678;

   mcd_port uut (.clock(clock), .rst(rst), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_wr(req_wr), .req_rd(req_rd), .req_size(req_size), .rd_data(rd_data),
      .size_err(size_err), .wb_refused(wb_refused), .wb_busy(wb_busy), .wb_valid(wb_valid),
      .wb_ready(wb_ready), .wb_addr(wb_addr), .wb_data(wb_data));

   mcd_mem_model mem (.clock(clock), .rst(rst), .slow(slow), .wb_valid(wb_valid),
      .wb_addr(wb_addr), .wb_data(wb_data), .wb_ready(wb_ready));

   // Address bits 1 and 0 are always driven to zero.
   function automatic logic [31:0] da(logic [1:0] w, logic [7:0] e, logic [1:0] l,
                                      logic [9:0] j);
      return {8'hF1, j, w, e, l, 2'b00};
   endfunction

   function automatic logic [31:0] ta(logic [1:0] w, logic [7:0] e, logic a);
      return {8'hF0, 10'h000, w, e, a, 3'b000};
   endfunction

   function automatic logic [31:0] tw(logic [18:0] t, logic [5:0] u, logic d, logic v);
      return {3'b000, t, u, 2'b00, d, v};
   endfunction

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s);
      req_addr  <= a;
      req_wdata <= d;
      req_size  <= s;
      req_wr    <= 1'b1;
      @(posedge clock);
      req_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [1:0] s, output logic [31:0] q,
                     output logic e);
      req_addr <= a;
      req_size <= s;
      req_rd   <= 1'b1;
      @(posedge clock);
      req_rd   <= 1'b0;
      #1;
      q = rd_data;
      e = size_err;
      @(posedge clock);
   endtask

   // A write is read back in the very next cycle, with other filler in bits 23 to 14.
   task automatic put(input logic [1:0] w, input logic [7:0] e, input logic [1:0] l);
      logic [31:0] d;
      logic [31:0] q;
      logic        er;
      d = $random(seed);
      wr(da(w, e, l, 10'($random(seed))), d, `MCD_SIZE_LONG);
      rd(da(w, e, l, 10'($random(seed))), `MCD_SIZE_LONG, q, er);
      `CHK(q, d)
      `CHK(er, 1'b0)
      shadow[{w, e, l}] = d;
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------
   // Clock, watchdog and test sequence
   // ------------------------------------
   initial clock = 1'b0;
   always #5 clock = ~clock;

   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end

   initial begin
      logic [31:0] q;
      logic        er;
      logic [31:0] k0;
      rst = 1'b1;
      req_wr = 1'b0;
      req_rd = 1'b0;
      req_size = 2'h0;
      req_addr = 32'h0000_0000;
      req_wdata = 32'h0000_0000;
      slow = 1'b0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      `CHK(wb_valid, 1'b0)
      for (int i = 0; i < 48; i++) begin
         if (i == 0)
            put(2'h0, 8'h00, 2'h0);
         else if (i == 1)
            put(2'h3, 8'hFF, 2'h3);
         else
            put(2'($random(seed)), 8'($random(seed)), 2'($random(seed)));
      end
      foreach (shadow[k]) begin
         rd(da(k[11:10], k[9:2], k[1:0], 10'h3FF), `MCD_SIZE_LONG, q, er);
         `CHK(q, shadow[k])
      end
      put(2'h1, 8'h33, 2'h2);
      k0 = da(2'h1, 8'h33, 2'h2, 10'h000);
      for (int s = 0; s < 4; s++) begin
         if (s != 2) begin
            wr(k0, ~shadow[{2'h1, 8'h33, 2'h2}], 2'(s));
            #1;
            `CHK(size_err, 1'b1)
            @(posedge clock);
         end
      end
      rd(k0, 2'h0, q, er);
      `CHK(q, 32'h0000_0000)
      `CHK(er, 1'b1)
      wr({8'hF2, k0[23:0]}, 32'hDEAD_BEEF, `MCD_SIZE_LONG);
      @(posedge clock);
      rd(k0, `MCD_SIZE_LONG, q, er);
      `CHK(q, shadow[{2'h1, 8'h33, 2'h2}])
      rd({8'hF2, k0[23:0]}, `MCD_SIZE_LONG, q, er);
      `CHK(q, 32'h0000_0000)
      for (int l = 0; l < 4; l++) begin
         put(2'h2, en, 2'(l));
         put(2'h3, en, 2'(l));
      end
      wr(ta(2'h2, en, 1'b0), tw(tg, 6'h2A, 1'b1, 1'b1), `MCD_SIZE_LONG);
      rd(ta(2'h2, en, 1'b0), `MCD_SIZE_LONG, q, er);
      `CHK(q, tw(tg, 6'h2A, 1'b1, 1'b1))
      put(2'h2, en, 2'h1);
      rd(ta(2'h2, en, 1'b0), `MCD_SIZE_LONG, q, er);
      `CHK(q, tw(tg, 6'h2A, 1'b1, 1'b1))
      `CHK(mem.cap_addr.size(), 0)
      wr(ta(2'h0, en, 1'b1), tw(tg ^ 19'h0_0001, 6'h00, 1'b0, 1'b0), `MCD_SIZE_LONG);
      repeat (8) @(posedge clock);
      rd(ta(2'h2, en, 1'b0), `MCD_SIZE_LONG, q, er);
      `CHK(q, tw(tg, 6'h2A, 1'b1, 1'b1))
      `CHK(mem.cap_addr.size(), 0)
      wr(ta(2'h3, en, 1'b0), tw(tg2, 6'h2A, 1'b1, 1'b1), `MCD_SIZE_LONG);
      slow <= 1'b1;
      wr(ta(2'h0, en, 1'b1), tw(tg, 6'h00, 1'b0, 1'b0), `MCD_SIZE_LONG);
      // A second dirty eviction while the buffer drains must be turned away whole.
      wr(ta(2'h3, en, 1'b0), tw(tg, 6'h2A, 1'b0, 1'b0), `MCD_SIZE_LONG);
      #1;
      `CHK(wb_refused, 1'b1)
      `CHK(wb_busy, 1'b1)
      for (int n = 0; n < 200 && mem.cap_addr.size() < 4; n++)
         @(posedge clock);
      @(posedge clock);
      #1;
      `CHK(wb_valid, 1'b0)
      `CHK(mem.cap_addr.size(), 4)
      for (int b = 0; b < 4 && b < mem.cap_addr.size(); b++) begin
         `CHK(mem.cap_addr[b], {3'b000, tg, en[5:0], 4'h0} + 32'(4 * b))
         `CHK(mem.cap_data[b], shadow[{2'h2, en, 2'(b)}])
      end
      @(posedge clock);
      rd(ta(2'h2, en, 1'b0), `MCD_SIZE_LONG, q, er);
      `CHK(q, tw(tg, 6'h2A, 1'b0, 1'b0))
      rd(ta(2'h3, en, 1'b0), `MCD_SIZE_LONG, q, er);
      `CHK(q, tw(tg2, 6'h2A, 1'b1, 1'b1))
      wr(ta(2'h3, en, 1'b0), tw(tg, 6'h2A, 1'b0, 1'b0), `MCD_SIZE_LONG);
      for (int n = 0; n < 200 && mem.cap_addr.size() < 8; n++)
         @(posedge clock);
      @(posedge clock);
      #1;
      `CHK(wb_valid, 1'b0)
      `CHK(mem.cap_addr.size(), 8)
      for (int b = 4; b < 8 && b < mem.cap_addr.size(); b++) begin
         `CHK(mem.cap_addr[b], {3'b000, tg2, en[5:0], 4'h0} + 32'(4 * (b - 4)))
         `CHK(mem.cap_data[b], shadow[{2'h3, en, 2'(b - 4)}])
      end
      @(posedge clock);
      rd(ta(2'h3, en, 1'b0), `MCD_SIZE_LONG, q, er);
      `CHK(q, tw(tg, 6'h2A, 1'b0, 1'b0))
      wrap_up();
   end
endmodule
